// File: core/latency_tolerance_select.sv
// latency_tolerance_select: picks the tolerance value reported to the
// usb host from ltm state and ethernet speed; holds inactivity timer
// assumes the fifo flags and speed come from logic on clk_i
`timescale 1ns/10ps
module latency_tolerance_select
#(
  parameter int TICK_CYCLES = ltm_pkg::TICK_CYCLES
)
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        usb_reset_i,
  input  wire logic        lite_soft_reset_i,
  // image loaded from eeprom or otp
  input  wire logic        image_valid_i,
  input  wire logic [31:0] image_idle_1g_100m_i,
  input  wire logic [31:0] image_idle_10m_i,
  input  wire logic [31:0] image_act_1g_100m_i,
  input  wire logic [31:0] image_act_10m_i,
  input  wire logic [31:0] image_inact_1g_100m_i,
  input  wire logic [31:0] image_inact_10m_i,
  // data path status
  input  wire logic [1:0]  link_speed_i,
  input  wire logic        usb_egress_buffer_empty_i,
  input  wire logic        usb_ingress_buffer_empty_i,
  input  wire logic        eth_receive_buffer_empty_i,
  input  wire logic        eth_transmit_buffer_empty_i,
  input  wire logic        bulk_out_pending_i,
  // register port
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_write_i,
  input  wire logic        reg_read_i,
  output logic [31:0]      reg_rdata_o,
  // tolerance report
  output logic [11:0]      tolerance_o,
  output logic             ltm_idle_o
);
  localparam int TW = ltm_pkg::TOL_W;
  localparam int RW = ltm_pkg::RELOAD_W;

  initial
  begin
    if (TICK_CYCLES < 2)
      $error("TICK_CYCLES too small");
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [31:0] idle_tolerance_1g_100m;
  logic [31:0] idle_tolerance_10m;
  logic [31:0] active_tolerance_1g_100m;
  logic [31:0] active_tolerance_10m;
  logic [31:0] inactivity_reload_1g_100m;
  logic [31:0] inactivity_reload_10m;
  logic        ltm_enable;
  logic [31:0] next_idle_1g_100m;
  logic [31:0] next_idle_10m;
  logic [31:0] next_act_1g_100m;
  logic [31:0] next_act_10m;
  logic [31:0] next_inact_1g_100m;
  logic [31:0] next_inact_10m;
  logic        next_ltm_enable;
  logic [31:0] next_rdata;
  logic        soft_reset;

  ltm_pkg::ltm_state_type state;
  ltm_pkg::ltm_state_type next_state;
  ltm_pkg::speed_type     speed;
  ltm_timer_if            tmr ();

  assign soft_reset = usb_reset_i || lite_soft_reset_i;
  assign speed      = ltm_pkg::speed_type'(link_speed_i);

  // image or zero when nothing was loaded
  function automatic logic [31:0] restore(input logic [31:0] img, input logic [31:0] keep);
    restore = image_valid_i ? (img & keep) : ltm_pkg::EMPTY_IMAGE;
  endfunction

  localparam logic [31:0] MASK_PAIR_TOL = 32'h0FFF_0FFF;
  localparam logic [31:0] MASK_ONE_TOL  = 32'h0000_0FFF;
  localparam logic [31:0] MASK_PAIR_RLD = 32'hFFFF_FFFF;
  localparam logic [31:0] MASK_ONE_RLD  = 32'h0000_FFFF;

  always_comb
  begin
    next_idle_1g_100m  = idle_tolerance_1g_100m;
    next_idle_10m      = idle_tolerance_10m;
    next_act_1g_100m   = active_tolerance_1g_100m;
    next_act_10m       = active_tolerance_10m;
    next_inact_1g_100m = inactivity_reload_1g_100m;
    next_inact_10m     = inactivity_reload_10m;
    next_ltm_enable    = ltm_enable;
    if (soft_reset)
    begin
      next_idle_1g_100m  = restore(image_idle_1g_100m_i, MASK_PAIR_TOL);
      next_idle_10m      = restore(image_idle_10m_i, MASK_ONE_TOL);
      next_act_1g_100m   = restore(image_act_1g_100m_i, MASK_PAIR_TOL);
      next_act_10m       = restore(image_act_10m_i, MASK_ONE_TOL);
      next_inact_1g_100m = restore(image_inact_1g_100m_i, MASK_PAIR_RLD);
      next_inact_10m     = restore(image_inact_10m_i, MASK_ONE_RLD);
      next_ltm_enable    = 1'b0;
    end
    else if (reg_write_i)
    begin
      unique case (reg_addr_i)
        ltm_pkg::IDLE_TOL_1G_100M_OFS: next_idle_1g_100m  = reg_wdata_i & MASK_PAIR_TOL;
        ltm_pkg::IDLE_TOL_10M_OFS:     next_idle_10m      = reg_wdata_i & MASK_ONE_TOL;
        ltm_pkg::ACT_TOL_1G_100M_OFS:  next_act_1g_100m   = reg_wdata_i & MASK_PAIR_TOL;
        ltm_pkg::ACT_TOL_10M_OFS:      next_act_10m       = reg_wdata_i & MASK_ONE_TOL;
        ltm_pkg::INACT_1G_100M_OFS:    next_inact_1g_100m = reg_wdata_i;
        ltm_pkg::INACT_10M_OFS:        next_inact_10m     = reg_wdata_i & MASK_ONE_RLD;
        ltm_pkg::LTM_CTRL_OFS:         next_ltm_enable    = reg_wdata_i[0];
        default:                       next_ltm_enable    = ltm_enable;
      endcase
    end
  end

  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if (reg_read_i)
    begin
      unique case (reg_addr_i)
        ltm_pkg::IDLE_TOL_1G_100M_OFS: next_rdata = idle_tolerance_1g_100m;
        ltm_pkg::IDLE_TOL_10M_OFS:     next_rdata = idle_tolerance_10m;
        ltm_pkg::ACT_TOL_1G_100M_OFS:  next_rdata = active_tolerance_1g_100m;
        ltm_pkg::ACT_TOL_10M_OFS:      next_rdata = active_tolerance_10m;
        ltm_pkg::INACT_1G_100M_OFS:    next_rdata = inactivity_reload_1g_100m;
        ltm_pkg::INACT_10M_OFS:        next_rdata = inactivity_reload_10m;
        ltm_pkg::LTM_CTRL_OFS:         next_rdata = {31'h0000_0000, ltm_enable};
        ltm_pkg::LTM_STATUS_OFS:       next_rdata = {30'h0000_0000, tmr.running, ltm_idle_o};
        default:                       next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      idle_tolerance_1g_100m    <= ltm_pkg::EMPTY_IMAGE;
      idle_tolerance_10m        <= ltm_pkg::EMPTY_IMAGE;
      active_tolerance_1g_100m  <= ltm_pkg::EMPTY_IMAGE;
      active_tolerance_10m      <= ltm_pkg::EMPTY_IMAGE;
      inactivity_reload_1g_100m <= ltm_pkg::EMPTY_IMAGE;
      inactivity_reload_10m     <= ltm_pkg::EMPTY_IMAGE;
      ltm_enable                <= 1'b0;
      reg_rdata_o               <= 32'h0000_0000;
    end
    else
    begin
      idle_tolerance_1g_100m    <= next_idle_1g_100m;
      idle_tolerance_10m        <= next_idle_10m;
      active_tolerance_1g_100m  <= next_act_1g_100m;
      active_tolerance_10m      <= next_act_10m;
      inactivity_reload_1g_100m <= next_inact_1g_100m;
      inactivity_reload_10m     <= next_inact_10m;
      ltm_enable                <= next_ltm_enable;
      reg_rdata_o               <= next_rdata;
    end
  end

  // ------------------------------------------------------------
  // inactivity timer and ltm state
  // ------------------------------------------------------------
  logic quiet;
  logic [RW-1:0] reload_count_1g;
  logic [RW-1:0] reload_count_100m;
  logic [RW-1:0] reload_count_10m;

  assign reload_count_1g   = inactivity_reload_1g_100m[ltm_pkg::RELOAD_HI_LSB +: RW];
  assign reload_count_100m = inactivity_reload_1g_100m[ltm_pkg::RELOAD_LO_LSB +: RW];
  assign reload_count_10m  = inactivity_reload_10m[ltm_pkg::RELOAD_LO_LSB +: RW];

  assign quiet = usb_egress_buffer_empty_i && usb_ingress_buffer_empty_i
              && eth_receive_buffer_empty_i && eth_transmit_buffer_empty_i
              && !bulk_out_pending_i;

  always_comb
  begin
    unique case (speed)
      ltm_pkg::SPEED_1G:   tmr.reload = reload_count_1g;
      ltm_pkg::SPEED_100M: tmr.reload = reload_count_100m;
      default:             tmr.reload = reload_count_10m;
    endcase
    // load once on entry to quiet; a running count is not restarted
    tmr.load = ltm_enable && quiet && state == ltm_pkg::LTM_ACTIVE;
    tmr.stop = !ltm_enable || !quiet || soft_reset;
  end

  ltm_inact_timer #(.TICK_CYCLES(TICK_CYCLES)) u_timer
  (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .tmr     (tmr)
  );

  always_comb
  begin
    next_state = state;
    unique case (state)
      ltm_pkg::LTM_ACTIVE:
        // a load that a soft reset overrides must not leave count unarmed
        if (tmr.load && !tmr.stop)
          next_state = ltm_pkg::LTM_COUNT;
      ltm_pkg::LTM_COUNT:
        if (tmr.stop)
          next_state = ltm_pkg::LTM_ACTIVE;
        else if (tmr.expired)
          next_state = ltm_pkg::LTM_IDLE;
      ltm_pkg::LTM_IDLE:
        if (tmr.stop)
          next_state = ltm_pkg::LTM_ACTIVE;
      default:
        next_state = ltm_pkg::LTM_ACTIVE;
    endcase
  end

  // ------------------------------------------------------------
  // tolerance selection
  // ------------------------------------------------------------
  logic [TW-1:0] next_tolerance;
  logic          idle_now;

  assign idle_now = next_state == ltm_pkg::LTM_IDLE;

  always_comb
  begin
    next_tolerance = '0;
    unique case (speed)
      ltm_pkg::SPEED_1G:
        next_tolerance = idle_now ? idle_tolerance_1g_100m[ltm_pkg::TOL_HI_LSB +: TW]
                                  : active_tolerance_1g_100m[ltm_pkg::TOL_HI_LSB +: TW];
      ltm_pkg::SPEED_100M:
        next_tolerance = idle_now ? idle_tolerance_1g_100m[ltm_pkg::TOL_LO_LSB +: TW]
                                  : active_tolerance_1g_100m[ltm_pkg::TOL_LO_LSB +: TW];
      default:
        next_tolerance = idle_now ? idle_tolerance_10m[ltm_pkg::TOL_LO_LSB +: TW]
                                  : active_tolerance_10m[ltm_pkg::TOL_LO_LSB +: TW];
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state       <= ltm_pkg::LTM_ACTIVE;
      tolerance_o <= '0;
      ltm_idle_o  <= 1'b0;
    end
    else
    begin
      state       <= next_state;
      tolerance_o <= next_tolerance;
      ltm_idle_o  <= idle_now;
    end
  end

  a_active_1g: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !ltm_idle_o && speed == ltm_pkg::SPEED_1G && $stable(speed) && $stable(active_tolerance_1g_100m)
    |-> tolerance_o == active_tolerance_1g_100m[27:16])
    else $error("gigabit active tolerance wrong");
  a_active_10m: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !ltm_idle_o && speed == ltm_pkg::SPEED_10M && $stable(speed) && $stable(active_tolerance_10m)
    |-> tolerance_o == active_tolerance_10m[11:0])
    else $error("10m active tolerance wrong");
  a_idle_10m: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ltm_idle_o && speed == ltm_pkg::SPEED_10M && $stable(speed) && $stable(idle_tolerance_10m)
    |-> tolerance_o == idle_tolerance_10m[11:0])
    else $error("10m idle tolerance wrong");
  a_idle_100m: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ltm_idle_o && speed == ltm_pkg::SPEED_100M && $stable(speed) && $stable(idle_tolerance_1g_100m)
    |-> tolerance_o == idle_tolerance_1g_100m[11:0])
    else $error("100m idle tolerance wrong");
  a_load_counts: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    tmr.load && !tmr.stop |=> tmr.running)
    else $error("quiet data path did not arm timer");
  a_zero_idle: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    state == ltm_pkg::LTM_COUNT && tmr.expired && !tmr.stop |=> ltm_idle_o)
    else $error("expired timer did not enter idle");
  a_reset_clear: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    soft_reset && !image_valid_i |=> active_tolerance_10m == 32'h0000_0000 && !ltm_enable)
    else $error("soft reset did not clear fields");
  a_busy_wakes: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ltm_idle_o && !quiet |=> !ltm_idle_o)
    else $error("activity did not leave idle");

endmodule // latency_tolerance_select

// File: shared/ltm_pkg.sv
// ltm_pkg: register map, field layout, speeds and timing constants
// for the latency tolerance selector; shared by core and bench
package ltm_pkg;

  // register byte offsets
  localparam logic [7:0] IDLE_TOL_1G_100M_OFS  = 8'hE0;
  localparam logic [7:0] IDLE_TOL_10M_OFS      = 8'hE4;
  localparam logic [7:0] ACT_TOL_1G_100M_OFS   = 8'hE8;
  localparam logic [7:0] ACT_TOL_10M_OFS       = 8'hEC;
  localparam logic [7:0] INACT_1G_100M_OFS     = 8'hF0;
  localparam logic [7:0] INACT_10M_OFS         = 8'hF4;
  localparam logic [7:0] LTM_CTRL_OFS          = 8'hF8;
  localparam logic [7:0] LTM_STATUS_OFS        = 8'hFC;

  // field layout
  localparam int TOL_W       = 12;
  localparam int TOL_HI_LSB  = 16;
  localparam int TOL_LO_LSB  = 0;
  localparam int RELOAD_W    = 16;
  localparam int RELOAD_HI_LSB = 16;
  localparam int RELOAD_LO_LSB = 0;

  // image value when no eeprom/otp image exists
  localparam logic [31:0] EMPTY_IMAGE = 32'h0000_0000;

  // timing
  localparam int CLK_MHZ     = 125;
  localparam int TICK_US     = 100;
  localparam int TICK_CYCLES = TICK_US * CLK_MHZ;

  typedef enum logic [1:0]
  {
    SPEED_10M  = 2'h0,
    SPEED_100M = 2'h1,
    SPEED_1G   = 2'h2
  } speed_type;

  typedef enum logic [1:0]
  {
    LTM_ACTIVE = 2'h0,
    LTM_COUNT  = 2'h1,
    LTM_IDLE   = 2'h3
  } ltm_state_type;

endpackage

// File: shared/ltm_timer_if.sv
// ltm_timer_if: carries load, reload value and expiry between the
// selector and its inactivity timer; one clock, same domain
`timescale 1ns/10ps
interface ltm_timer_if;
  logic        load;
  logic        stop;
  logic [15:0] reload;
  logic        expired;
  logic        running;

  modport owner
  (
    output load,
    output stop,
    output reload,
    input  expired,
    input  running
  );
  modport timer
  (
    input  load,
    input  stop,
    input  reload,
    output expired,
    output running
  );
endinterface

// File: core/ltm_tick_gen.sv
// ltm_tick_gen: one-cycle pulse every 100 us of the device clock
// assumes clk_i at the rate given in the package
`timescale 1ns/10ps
module ltm_tick_gen
#(
  parameter int TICK_CYCLES = ltm_pkg::TICK_CYCLES
)
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  // restart and tick
  input  wire logic restart_i,
  output logic      tick_o
);
  localparam int CW = $clog2(TICK_CYCLES);

  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic          next_tick;

  initial
  begin
    if (TICK_CYCLES < 2)
      $error("tick period must be at least two cycles");
  end

  always_comb
  begin
    next_tick  = 1'b0;
    next_count = count - 1'b1;
    if (restart_i)
      next_count = CW'(TICK_CYCLES - 1);
    else if (count == '0)
    begin
      next_tick  = 1'b1;
      next_count = CW'(TICK_CYCLES - 1);
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      count  <= '0;
      tick_o <= 1'b0;
    end
    else
    begin
      count  <= next_count;
      tick_o <= next_tick;
    end
  end

  a_tick_spacing: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    tick_o && !restart_i |=> !tick_o)
    else $error("tick repeated in consecutive cycles");

endmodule // ltm_tick_gen

// File: core/ltm_inact_timer.sv
// ltm_inact_timer: 16-bit down counter in 100 us units
// assumes the owner pulses load for one cycle when the data path goes quiet
`timescale 1ns/10ps
module ltm_inact_timer
#(
  parameter int TICK_CYCLES = ltm_pkg::TICK_CYCLES
)
(
  // clock and reset
  input  wire logic  clk_i,
  input  wire logic  rst_b_i,
  // control
  ltm_timer_if.timer tmr
);
  logic [15:0] count;
  logic [15:0] next_count;
  logic        armed;
  logic        next_armed;
  logic        tick;

  ltm_tick_gen #(.TICK_CYCLES(TICK_CYCLES)) u_tick
  (
    .clk_i     (clk_i),
    .rst_b_i   (rst_b_i),
    .restart_i (tmr.load),
    .tick_o    (tick)
  );

  always_comb
  begin
    next_count = count;
    next_armed = armed;
    if (tmr.stop)
      next_armed = 1'b0;
    else if (tmr.load)
    begin
      next_count = tmr.reload;
      next_armed = 1'b1;
    end
    else if (armed && tick && count != '0)
      next_count = count - 16'h0001;
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      count <= '0;
      armed <= 1'b0;
    end
    else
    begin
      count <= next_count;
      armed <= next_armed;
    end
  end

  assign tmr.expired = armed && count == '0;
  assign tmr.running = armed;

  a_count_down: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    armed && !tmr.load && !tmr.stop && tick && count != '0 |=> count == $past(count) - 16'h0001)
    else $error("timer failed to decrement on tick");

endmodule // ltm_inact_timer

// File: tb/host_ltm_model.sv
// host_ltm_model: stands in for the usb host that hears tolerance reports
// assumes tolerance and idle flag are registered on clk_i by the device
`timescale 1ns/10ps
module host_ltm_model
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  // reports from the device
  input  wire logic [11:0] tolerance_i,
  input  wire logic        idle_i,
  // what the host has heard
  output logic [11:0]      heard_tolerance_o,
  output logic [7:0]       idle_entries_o
);
  logic idle_seen;

  // ----------------------------------------
  // report capture
  // ----------------------------------------
  // host only counts rising idle reports, not the level
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      heard_tolerance_o <= 12'h000;
      idle_entries_o    <= 8'h00;
      idle_seen         <= 1'b0;
    end
    else
    begin
      heard_tolerance_o <= tolerance_i;
      idle_seen         <= idle_i;
      if (idle_i && !idle_seen)
        idle_entries_o <= idle_entries_o + 8'h01;
    end
  end
endmodule // host_ltm_model

// File: tb/tb_latency_tolerance_select.sv
// tb_latency_tolerance_select: register, selection, timer and reset tests
// assumes a 125 MHz clock and a shortened tick of TICK cycles
`timescale 1ns/10ps
module tb_latency_tolerance_select;
  localparam int TICK = 4;

  logic        clk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic        usb_reset_i = 1'b0;
  logic        lite_soft_reset_i = 1'b0;
  logic        image_valid_i = 1'b0;
  logic [31:0] img [6];
  logic [1:0]  link_speed_i = 2'h0;
  logic [4:0]  empty_n = 5'h00;
  logic [7:0]  reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic        reg_write_i = 1'b0;
  logic        reg_read_i = 1'b0;
  logic [31:0] reg_rdata_o;
  logic [11:0] tolerance_o;
  logic        ltm_idle_o;
  logic [11:0] heard;
  logic [7:0]  entries;
  logic [7:0]  ofs [6];
  logic [31:0] msk [6];
  int          fail_count = 0;
  int          checks_done = 0;
  int          cycles = 0;

  always #4 clk_i = ~clk_i;

  latency_tolerance_select #(.TICK_CYCLES(TICK)) DUT
  (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .usb_reset_i(usb_reset_i),
    .lite_soft_reset_i(lite_soft_reset_i), .image_valid_i(image_valid_i),
    .image_idle_1g_100m_i(img[0]), .image_idle_10m_i(img[1]), .image_act_1g_100m_i(img[2]),
    .image_act_10m_i(img[3]), .image_inact_1g_100m_i(img[4]), .image_inact_10m_i(img[5]),
    .link_speed_i(link_speed_i),
    .usb_egress_buffer_empty_i(!empty_n[0]), .usb_ingress_buffer_empty_i(!empty_n[1]),
    .eth_receive_buffer_empty_i(!empty_n[2]), .eth_transmit_buffer_empty_i(!empty_n[3]),
    .bulk_out_pending_i(empty_n[4]),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i),
    .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o),
    .tolerance_o(tolerance_o), .ltm_idle_o(ltm_idle_o)
  );

  host_ltm_model host
  (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .tolerance_i(tolerance_o), .idle_i(ltm_idle_o),
    .heard_tolerance_o(heard), .idle_entries_o(entries)
  );

  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    if (fail_count == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // hang guard, generous against the few hundred cycles needed
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      give_verdict();
    end
  end

  // ----------------------------------------
  // register port tasks
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_write_i <= 1'b1;
    @(posedge clk_i);
    reg_write_i <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_read_i <= 1'b1;
    @(posedge clk_i);
    reg_read_i <= 1'b0;
    #1;
    check(reg_rdata_o, exp);
  endtask

  task automatic tol_chk(input logic [1:0] spd, input logic [11:0] exp);
    @(posedge clk_i);
    link_speed_i <= spd;
    repeat (3) @(posedge clk_i);
    #1;
    check({20'h0, tolerance_o}, {20'h0, exp});
  endtask

  // quiet data path until idle, then wake it with one busy source
  task automatic run_idle(input logic [1:0] spd, input int rl, input logic [11:0] act,
                          input logic [11:0] idl, input int src);
    int n;
    n = 0;
    @(posedge clk_i);
    link_speed_i <= spd;
    empty_n      <= 5'h00;
    while (ltm_idle_o !== 1'b1 && n < 200)
    begin
      @(posedge clk_i);
      #1;
      n++;
    end
    // expiry time follows the speed's reload
    check(32'(n >= rl * TICK - 1 && n <= rl * TICK + 6), 32'h1);
    check({20'h0, tolerance_o}, {20'h0, idl});
    rd_chk(ltm_pkg::LTM_STATUS_OFS, 32'h00000003);
    @(posedge clk_i);
    empty_n[src] <= 1'b1;
    @(posedge clk_i);
    #1;
    check({31'h0, ltm_idle_o}, 32'h0);
    check({20'h0, tolerance_o}, {20'h0, act});
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    ofs = '{ltm_pkg::IDLE_TOL_1G_100M_OFS, ltm_pkg::IDLE_TOL_10M_OFS, ltm_pkg::ACT_TOL_1G_100M_OFS,
            ltm_pkg::ACT_TOL_10M_OFS, ltm_pkg::INACT_1G_100M_OFS, ltm_pkg::INACT_10M_OFS};
    msk = '{32'h0FFF0FFF, 32'h00000FFF, 32'h0FFF0FFF, 32'h00000FFF, 32'hFFFFFFFF, 32'h0000FFFF};
    img = '{32'h0ABC0DEF, 32'h00000123, 32'h01110222, 32'h00000333, 32'h00050006, 32'h00000007};
    repeat (10) @(posedge clk_i);
    rst_b_i <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      rd_chk(ofs[i], ltm_pkg::EMPTY_IMAGE);
      wr(ofs[i], 32'hFFFFFFFF);
      rd_chk(ofs[i], msk[i]);
    end
    wr(8'h10, 32'hFFFFFFFF);
    rd_chk(8'h10, 32'h0);
    wr(ltm_pkg::IDLE_TOL_1G_100M_OFS, 32'h01A101B2);
    wr(ltm_pkg::IDLE_TOL_10M_OFS, 32'h000000C3);
    wr(ltm_pkg::ACT_TOL_1G_100M_OFS, 32'h02D402E5);
    wr(ltm_pkg::ACT_TOL_10M_OFS, 32'h000002F6);
    wr(ltm_pkg::INACT_1G_100M_OFS, 32'h00040002);
    wr(ltm_pkg::INACT_10M_OFS, 32'h00000007);
    tol_chk(2'h2, 12'h2D4);
    tol_chk(2'h1, 12'h2E5);
    tol_chk(2'h0, 12'h2F6);
    tol_chk(2'h3, 12'h2F6);
    // quiet but not enabled: must stay active
    repeat (40) @(posedge clk_i);
    #1;
    check({31'h0, ltm_idle_o}, 32'h0);
    // busy before enabling, so the first load uses the first run's speed
    @(posedge clk_i);
    empty_n <= 5'h01;
    wr(ltm_pkg::LTM_CTRL_OFS, 32'h00000001);
    run_idle(2'h2, 4, 12'h2D4, 12'h1A1, 0);
    run_idle(2'h1, 2, 12'h2E5, 12'h1B2, 1);
    run_idle(2'h0, 7, 12'h2F6, 12'h0C3, 2);
    run_idle(2'h2, 4, 12'h2D4, 12'h1A1, 3);
    run_idle(2'h1, 2, 12'h2E5, 12'h1B2, 4);
    // host hears the report one cycle after the device drives it
    @(posedge clk_i);
    #1;
    check({24'h0, entries}, 32'h5);
    check({20'h0, heard}, 32'h2E5);
    // soft resets restore the image, or zero without one
    @(posedge clk_i);
    image_valid_i <= 1'b1;
    usb_reset_i   <= 1'b1;
    @(posedge clk_i);
    usb_reset_i <= 1'b0;
    for (int i = 0; i < 6; i++)
      rd_chk(ofs[i], img[i] & msk[i]);
    rd_chk(ltm_pkg::LTM_CTRL_OFS, 32'h0);
    @(posedge clk_i);
    image_valid_i     <= 1'b0;
    lite_soft_reset_i <= 1'b1;
    @(posedge clk_i);
    lite_soft_reset_i <= 1'b0;
    for (int i = 0; i < 6; i++)
      rd_chk(ofs[i], ltm_pkg::EMPTY_IMAGE);
    give_verdict();
  end
endmodule // tb_latency_tolerance_select
